//--- hw/serial_pin_interrupt_router.v
/*
  Serial pin and interrupt router with port B pad control.
  Routes async serial 0, sync serial 0 and two-wire 0 onto port 2 or port B pins,
  swaps async receive/transmit pins, selects the timer A0 capture input and maps
  the unit interrupts onto the shared latch slots.
  Assumes single-cycle SFR strobes and pin inputs synchronous to clk_sys; port 2
  and port 9 pad logic applies its own alternate-function bits outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "serial_pin_router_regs.vh"

module serial_pin_interrupt_router
(
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst_b,
  // Special-function-register access
  input  wire [11:0] sfr_addr,
  input  wire        sfr_wr,
  input  wire        sfr_rd,
  input  wire [7:0]  sfr_wdata,
  output reg  [7:0]  sfr_rdata,
  // Port B pad (bits 7..4)
  input  wire [3:0]  pb_in,
  output reg  [3:0]  pb_out,
  output reg  [3:0]  pb_oe,
  // Port 2 bits 5..0 and port 9 bits 1..0 function side
  input  wire [5:0]  p2_in,
  output reg  [5:0]  p2_fn_out,
  output reg  [5:0]  p2_fn_used,
  input  wire [1:0]  p9_in,
  output reg  [1:0]  p9_fn_out,
  // Outputs from the serial units
  input  wire        async0_transmit,
  input  wire        async1_transmit,
  input  wire        sync0_serial_out,
  input  wire        sync0_shift_clock,
  input  wire        two_wire0_data_low,
  input  wire        two_wire0_clock_low,
  // Inputs to the serial units and timer
  output reg         async0_receive,
  output reg         async1_receive,
  output reg         sync0_serial_in,
  output reg         two_wire0_data,
  output reg         two_wire0_clock,
  output reg         timer_a0_capture,
  // Interrupt sources and shared latch slots
  input  wire        async0_transmit_irq,
  input  wire        async0_receive_irq,
  input  wire        sync0_irq,
  input  wire        two_wire0_irq,
  output reg         latch_slot_seven,
  output reg         latch_slot_six,
  output reg         latch_slot_fifteen
);

  // Control registers
  reg  [7:0] pb_latch_q;
  reg  [7:0] port_b_direction_q;
  reg  [7:0] port_b_alt_function_q;
  reg  [7:0] port_b_drive_type_q;
  reg  [7:0] async_pin_swap_q;
  reg  [7:0] serial_routing_select_q;

  // Decoded fields
  wire [1:0] serial_pair_select     = serial_routing_select_q[`BIT_PAIR_HI:`BIT_PAIR_LO];
  wire       serial_pin_group_select = serial_routing_select_q[`BIT_PIN_GROUP];
  wire [1:0] timer_a0_input_select  = serial_routing_select_q[`BIT_TIMER_HI:`BIT_TIMER_LO];
  wire       async0_pin_swap        = async_pin_swap_q[`BIT_ASYNC0_SWAP];
  wire       async1_pin_swap        = async_pin_swap_q[`BIT_ASYNC1_SWAP];

  // Which units own pins this cycle; reserved code enables none
  wire async_on  = (serial_pair_select == `PAIR_ASYNC_TWI) ||
                   (serial_pair_select == `PAIR_ASYNC_SYNC);
  wire sync_grp  = (serial_pair_select == `PAIR_SYNC_TWI);
  wire sync_p2hi = (serial_pair_select == `PAIR_ASYNC_SYNC);
  wire twi_on    = (serial_pair_select == `PAIR_ASYNC_TWI) ||
                   (serial_pair_select == `PAIR_SYNC_TWI);

  // Register writes; writes to read-only bits are dropped by the masks
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pb_latch_q              <= `RST_REG8;
      port_b_direction_q      <= `RST_REG8;
      port_b_alt_function_q   <= `RST_REG8;
      port_b_drive_type_q     <= `RST_REG8;
      async_pin_swap_q        <= `RST_REG8;
      serial_routing_select_q <= `RST_REG8;
    end
    else if (sfr_wr)
    begin
      case (sfr_addr)
        `OFS_PB_LATCH:      pb_latch_q <= sfr_wdata & `MASK_PB_LATCH;
        `OFS_PB_DIRECTION:  port_b_direction_q <= sfr_wdata & `MASK_PB_DIRECTION;
        `OFS_PB_ALT_FUNC:   port_b_alt_function_q <= sfr_wdata & `MASK_PB_ALT_FUNC;
        `OFS_PB_DRIVE_TYPE: port_b_drive_type_q <= sfr_wdata & `MASK_PB_DRIVE_TYPE;
        `OFS_ASYNC_SWAP:    async_pin_swap_q <= sfr_wdata & `MASK_ASYNC_SWAP;
        `OFS_ROUTING_SEL:   serial_routing_select_q <= sfr_wdata & `MASK_ROUTING_SEL;
        default:            pb_latch_q <= pb_latch_q;
      endcase
    end
  end

  // Shared group of three pins: index 0/1 carry async tx/rx or sync out/in, 2 sync clock
  reg [2:0] grp_out;
  reg [2:0] grp_used;
  reg [2:0] grp_in;
  always @*
  begin
    grp_out  = 3'b111;
    grp_used = 3'b000;
    grp_in   = serial_pin_group_select ? pb_in[2:0] : p2_in[2:0];
    if (async_on)
    begin
      grp_used = 3'b011;
      if (async0_pin_swap)
        grp_out[1] = async0_transmit;
      else
        grp_out[0] = async0_transmit;
    end
    else if (sync_grp)
    begin
      grp_used   = 3'b111;
      grp_out[0] = sync0_serial_out;
      grp_out[2] = sync0_shift_clock;
    end
  end

  // Port 2 upper pins: two-wire data/clock or sync serial under the async pair
  reg [2:0] hi_out;
  reg [2:0] hi_used;
  always @*
  begin
    hi_out  = 3'b111;
    hi_used = 3'b000;
    if (twi_on)
    begin
      hi_used   = 3'b011;
      hi_out[0] = ~two_wire0_data_low;
      hi_out[1] = ~two_wire0_clock_low;
    end
    else if (sync_p2hi)
    begin
      hi_used   = 3'b111;
      hi_out[0] = sync0_serial_out;
      hi_out[2] = sync0_shift_clock;
    end
  end

  // Port B drive value: latch or routed serial output on bits 6..4
  reg [3:0] pb_val;
  reg [3:0] pb_fn;
  always @*
  begin
    pb_fn  = serial_pin_group_select ? {1'b1, grp_out} : 4'hF;
    pb_val = pb_latch_q[7:4];
    if (port_b_alt_function_q[4])
      pb_val[0] = pb_fn[0];
    if (port_b_alt_function_q[5])
      pb_val[1] = pb_fn[1];
    if (port_b_alt_function_q[6])
      pb_val[2] = pb_fn[2];
  end

  // Registered routing, pads and interrupts; a new selection acts one cycle later
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pb_out             <= 4'h0;
      pb_oe              <= 4'h0;
      p2_fn_out          <= 6'h3F;
      p2_fn_used         <= 6'h00;
      p9_fn_out          <= 2'h3;
      async0_receive     <= 1'b1;
      async1_receive     <= 1'b1;
      sync0_serial_in    <= 1'b1;
      two_wire0_data     <= 1'b1;
      two_wire0_clock    <= 1'b1;
      timer_a0_capture   <= 1'b0;
      latch_slot_seven   <= 1'b0;
      latch_slot_six     <= 1'b0;
      latch_slot_fifteen <= 1'b0;
    end
    else
    begin
      // Output drives while direction is output; open drain releases on high
      pb_out <= pb_val;
      pb_oe  <= port_b_direction_q[7:4] & (~port_b_drive_type_q[7:4] | ~pb_val);
      // Port 2: pins left unused stay general ports
      p2_fn_out  <= {hi_out, serial_pin_group_select ? 3'b111 : grp_out};
      p2_fn_used <= {hi_used, serial_pin_group_select ? 3'b000 : grp_used};
      // Async serial 1 pin swap on port 9
      p9_fn_out <= async1_pin_swap ? {async1_transmit, 1'b1} : {1'b1, async1_transmit};
      async1_receive <= async1_pin_swap ? p9_in[0] : p9_in[1];
      // Unit inputs; idle high when the unit is not connected
      async0_receive  <= async_on ? (async0_pin_swap ? grp_in[0] : grp_in[1]) : 1'b1;
      sync0_serial_in <= sync_grp ? grp_in[1] : (sync_p2hi ? p2_in[4] : 1'b1);
      two_wire0_data  <= twi_on ? p2_in[3] : 1'b1;
      two_wire0_clock <= twi_on ? p2_in[4] : 1'b1;
      // Timer A0 capture source
      case (timer_a0_input_select)
        `TIMER_SEL_P21: timer_a0_capture <= p2_in[1];
        `TIMER_SEL_P91: timer_a0_capture <= p9_in[1];
        default:        timer_a0_capture <= 1'b0;
      endcase
      // Shared interrupt latch slots
      latch_slot_seven   <= async_on & async0_transmit_irq;
      latch_slot_six     <= (async_on & async0_receive_irq) | (sync_grp & sync0_irq);
      latch_slot_fifteen <= (twi_on & two_wire0_irq) | (sync_p2hi & sync0_irq);
    end
  end

  // Read data, registered one cycle after the read strobe; unmapped reads 0
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      sfr_rdata <= 8'h00;
    else if (sfr_rd)
    begin
      case (sfr_addr)
        `OFS_PB_LATCH:      sfr_rdata <= pb_latch_q;
        `OFS_PB_READBACK:   sfr_rdata <= {pb_in & (~port_b_direction_q[7:4] | port_b_drive_type_q[7:4]),
                                          4'h0};
        `OFS_PB_DIRECTION:  sfr_rdata <= port_b_direction_q;
        `OFS_PB_ALT_FUNC:   sfr_rdata <= port_b_alt_function_q;
        `OFS_PB_DRIVE_TYPE: sfr_rdata <= port_b_drive_type_q;
        `OFS_ASYNC_SWAP:    sfr_rdata <= async_pin_swap_q;
        `OFS_ROUTING_SEL:   sfr_rdata <= serial_routing_select_q;
        default:            sfr_rdata <= 8'h00;
      endcase
    end
  end

endmodule // serial_pin_interrupt_router

`default_nettype wire

//--- inc/serial_pin_router_regs.vh
/*
  Register offsets, writable-bit masks, field positions, codes and reset values
  for the serial pin and interrupt router.
  Assumes an 8-bit special-function-register path with 12-bit byte addresses.
*/
// How it works
// - Port B bits 7..4 choose push-pull (0) or open-drain (1); reset 0; bits 3..0 read 0.
// - Port B readback bit returns pin level for input or open-drain, else 0.
// - Only two of async0, sync0 and two-wire0 reach pins and interrupts together.
// - Pair code 00 async0+two-wire0, 01 async0+sync0, 10 sync0+two-wire0, 11 reserved.
// - Pin-group bit puts async0, and sync0 under code 10, on port 2 bits 0..2 (0) or port B 4..6 (1).
// - Timer A0 input field picks port 2 bit 1 (00) or port 9 bit 1 (01).
// - Async1 swap 0 puts receive on port 9 bit 1, transmit bit 0; 1 exchanges them.
// - Async0 swap 0: receive on group pin 1, transmit pin 0; 1 exchanges them.
// - Two-wire0 uses port 2 bits 3/4; sync0 under code 01 uses port 2 bits 3..5.
// - Unused routed pins are general ports once software clears their alternate bit.
// - Latch 7 async0 transmit; latch 6 receive or sync0; latch 15 two-wire0 or sync0.
// - Port B direction bits 7..4: 0 input, 1 output; reset to input.
// - Port B alternate bits 6..4: 0 pin from port latch, 1 from routed serial output.
`ifndef SERIAL_PIN_ROUTER_REGS_VH
`define SERIAL_PIN_ROUTER_REGS_VH

// Register byte addresses
`define OFS_PB_LATCH       12'h000B
`define OFS_PB_READBACK    12'h0018
`define OFS_PB_DIRECTION   12'h0F25
`define OFS_PB_ALT_FUNC    12'h0F3F
`define OFS_PB_DRIVE_TYPE  12'h0F4C
`define OFS_ASYNC_SWAP     12'h0F57
`define OFS_ROUTING_SEL    12'h0FCB

// Writable bits of each register
`define MASK_PB_LATCH      8'hF0
`define MASK_PB_DIRECTION  8'hF0
`define MASK_PB_ALT_FUNC   8'h70
`define MASK_PB_DRIVE_TYPE 8'hF0
`define MASK_ASYNC_SWAP    8'h03
`define MASK_ROUTING_SEL   8'hD3

// Reset values
`define RST_REG8           8'h00

// Field positions
`define BIT_ASYNC0_SWAP    0
`define BIT_ASYNC1_SWAP    1
`define BIT_PAIR_LO        0
`define BIT_PAIR_HI        1
`define BIT_PIN_GROUP      4
`define BIT_TIMER_LO       6
`define BIT_TIMER_HI       7

// Serial pair codes
`define PAIR_ASYNC_TWI     2'b00
`define PAIR_ASYNC_SYNC    2'b01
`define PAIR_SYNC_TWI      2'b10

// Timer A0 input codes
`define TIMER_SEL_P21      2'b00
`define TIMER_SEL_P91      2'b01

`endif

//--- dv/router_checker.sv
/* Port-level assertions for the serial pin and interrupt router.
   Sees only the top ports; bound in at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
`include "serial_pin_router_regs.vh"
module router_checker (
  // Clock, reset and register bus
  input wire logic        clk_sys, rst_b, sfr_wr, sfr_rd,
  input wire logic [11:0] sfr_addr,
  input wire logic [7:0]  sfr_wdata, sfr_rdata,
  // Pins and unit lines
  input wire logic [3:0]  pb_in,
  input wire logic [5:0]  p2_in, p2_fn_used,
  input wire logic [1:0]  p9_in, p9_fn_out,
  input wire logic        async1_transmit, async1_receive, timer_a0_capture,
  // Interrupt sources and slots
  input wire logic        async0_transmit_irq, async0_receive_irq, sync0_irq, two_wire0_irq,
  input wire logic        latch_slot_seven, latch_slot_six, latch_slot_fifteen
);
  logic [1:0] pair_q, tsel_q, swp_q;
  logic       grp_q;
  logic [3:0] dir_q, od_q;
  logic [2:0] slot_d;
  logic [5:0] used_d;
  logic       tmr_d;
  // Shadow copy of the fields as software writes them
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
      {pair_q, tsel_q, swp_q, grp_q, dir_q, od_q} <= '0;
    else if (sfr_wr)
    begin
      if (sfr_addr == `OFS_ROUTING_SEL) {tsel_q, grp_q, pair_q} <= {sfr_wdata[7:6], sfr_wdata[4], sfr_wdata[1:0]};
      if (sfr_addr == `OFS_ASYNC_SWAP) swp_q <= sfr_wdata[1:0];
      if (sfr_addr == `OFS_PB_DIRECTION) dir_q <= sfr_wdata[7:4];
      if (sfr_addr == `OFS_PB_DRIVE_TYPE) od_q <= sfr_wdata[7:4];
    end
  // Expected slots, used pins and capture input for the shadow fields
  assign slot_d[2] = async0_transmit_irq & ~pair_q[1];
  assign slot_d[1] = (pair_q == 2'b10) ? sync0_irq : async0_receive_irq & ~pair_q[1];
  assign slot_d[0] = (pair_q == 2'b01) ? sync0_irq : two_wire0_irq & (pair_q != 2'b11);
  assign used_d = (pair_q == 2'b11) ? 6'h00 : {pair_q == 2'b01, 2'b11, pair_q == 2'b10 && !grp_q, !grp_q, !grp_q};
  assign tmr_d = (tsel_q == 2'b00) ? p2_in[1] : (tsel_q == 2'b01) & p9_in[1];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_rd(a);
    sfr_rd && sfr_addr == a;
  endsequence
  sequence s_wr_reserved;
    sfr_wr && sfr_addr == `OFS_ROUTING_SEL && sfr_wdata[1:0] == 2'b11;
  endsequence
  property p_unmapped_rd;
    sfr_rd && !(sfr_addr inside {`OFS_PB_LATCH, `OFS_PB_READBACK, `OFS_PB_DIRECTION, `OFS_PB_ALT_FUNC,
      `OFS_PB_DRIVE_TYPE, `OFS_ASYNC_SWAP, `OFS_ROUTING_SEL}) |=> sfr_rdata == 8'h00;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
  property p_drive_rd;
    s_rd(`OFS_PB_DRIVE_TYPE) |=> sfr_rdata == {$past(od_q), 4'h0};
  endproperty
  a_drive_rd: assert property (p_drive_rd) else $error("drive type readback wrong");
  property p_pin_rd;
    s_rd(`OFS_PB_READBACK) |=> sfr_rdata == {$past(pb_in & (~dir_q | od_q)), 4'h0};
  endproperty
  a_pin_rd: assert property (p_pin_rd) else $error("pin readback wrong");
  property p_used;
    $past(rst_b) |-> p2_fn_used == $past(used_d);
  endproperty
  a_used: assert property (p_used) else $error("routed pin set wrong");
  property p_slots;
    $past(rst_b) |-> {latch_slot_seven, latch_slot_six, latch_slot_fifteen} == $past(slot_d);
  endproperty
  a_slots: assert property (p_slots) else $error("interrupt slot wrong");
  property p_async1;
    $past(rst_b) |-> async1_receive == $past(swp_q[1] ? p9_in[0] : p9_in[1])
      && p9_fn_out == $past(swp_q[1] ? {async1_transmit, 1'b1} : {1'b1, async1_transmit});
  endproperty
  a_async1: assert property (p_async1) else $error("async1 placement wrong");
  property p_timer;
    $past(rst_b) |-> timer_a0_capture == $past(tmr_d);
  endproperty
  a_timer: assert property (p_timer) else $error("timer capture input wrong");
  property p_reserved;
    s_wr_reserved |-> ##2 p2_fn_used == 6'h00 && !latch_slot_six && !latch_slot_fifteen;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code routed something");
endmodule  // router_checker
bind serial_pin_interrupt_router router_checker u_chk (.*);
`default_nettype wire

//--- dv/router_far_side.sv
/* Far-side model: port B pads and the serial unit outputs.
   A released pad pin shows the external level given by the bench. */
`timescale 1ns/1ps
`default_nettype none
module router_far_side (
  // Port B pad
  input wire logic [3:0] pb_out, pb_oe, pb_ext,
  output logic     [3:0] pb_in,
  // Unit lines as commanded by the bench
  input wire logic [9:0] unit_cmd,
  output logic           async0_transmit, async1_transmit, sync0_serial_out, sync0_shift_clock,
  output logic           two_wire0_data_low, two_wire0_clock_low,
  output logic           async0_transmit_irq, async0_receive_irq, sync0_irq, two_wire0_irq
);
  // Driven pin shows the drive, released pin the outside level
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_ext);
  // Units idle unless the bench commands activity
  assign {async0_transmit, async1_transmit, sync0_serial_out, sync0_shift_clock, two_wire0_data_low,
    two_wire0_clock_low, async0_transmit_irq, async0_receive_irq, sync0_irq, two_wire0_irq} = unit_cmd;
endmodule  // router_far_side
`default_nettype wire

//--- dv/serial_pin_interrupt_router_test.sv
/* Register and pin-routing tests for the router.
   Assumes the far-side model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "serial_pin_router_regs.vh"
module serial_pin_interrupt_router_test;
  logic        clk_sys, rst_b, sfr_wr, sfr_rd;
  logic [11:0] sfr_addr;
  logic [7:0]  sfr_wdata, sfr_rdata;
  logic [3:0]  pb_in, pb_out, pb_oe, pb_ext;
  logic [5:0]  p2_in, p2_fn_out, p2_fn_used;
  logic [1:0]  p9_in, p9_fn_out;
  logic [9:0]  unit_cmd;
  logic        async0_transmit, async1_transmit, sync0_serial_out, sync0_shift_clock;
  logic        two_wire0_data_low, two_wire0_clock_low, async0_receive, async1_receive;
  logic        sync0_serial_in, two_wire0_data, two_wire0_clock, timer_a0_capture;
  logic        async0_transmit_irq, async0_receive_irq, sync0_irq, two_wire0_irq;
  logic        latch_slot_seven, latch_slot_six, latch_slot_fifteen;
  int          err_total = 0;
  int          tests_run = 0;
  int          cyc = 0;
  logic [11:0] adr [6] = '{`OFS_PB_DRIVE_TYPE, `OFS_ASYNC_SWAP, `OFS_ROUTING_SEL, `OFS_PB_DIRECTION,
                           `OFS_PB_ALT_FUNC, `OFS_PB_LATCH};
  logic [7:0]  msk [6] = '{8'hF0, 8'h03, 8'hD3, 8'hF0, 8'h70, 8'hF0};
  logic [7:0]  used_t [8] = '{8'h1B, 8'h3B, 8'h1F, 8'h00, 8'h18, 8'h38, 8'h18, 8'h00};
  logic [7:0]  slot_t [8] = '{8'h07, 8'h07, 8'h03, 8'h00, 8'h07, 8'h07, 8'h03, 8'h00};
  // Slots expected with only the sync serial source raised
  logic [7:0]  sync_t [8] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00};
  serial_pin_interrupt_router dut (.*);
  router_far_side far (.*);
  // System clock
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      final_report();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clk_sys);
    sfr_rd <= 1'b0;
    @(posedge clk_sys);
    chk(sfr_rdata, exp);
  endtask
  task automatic cfg(input logic [7:0] sel, input logic [7:0] swp, input logic [5:0] p2, input logic [1:0] p9);
    wr(`OFS_ROUTING_SEL, sel);
    wr(`OFS_ASYNC_SWAP, swp);
    p2_in <= p2;
    p9_in <= p9;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // Main sequence
  initial
  begin
    {rst_b, sfr_wr, sfr_rd, sfr_addr, sfr_wdata, pb_ext, p2_in, p9_in, unit_cmd} = '0;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++)
      rd(adr[i], 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wr(adr[i], 8'hFF);
      rd(adr[i], msk[i]);
      wr(adr[i], 8'h00);
    end
    wr(12'h0FFF, 8'hFF);
    rd(12'h0FFF, 8'h00);
    $display("register test done");
    wr(`OFS_PB_LATCH, 8'hF0);
    wr(`OFS_PB_DRIVE_TYPE, 8'h30);
    wr(`OFS_PB_DIRECTION, 8'hF0);
    pb_ext <= 4'hF;
    rd(`OFS_PB_READBACK, 8'h30);
    chk({4'h0, pb_oe}, 8'h0C);
    wr(`OFS_PB_DIRECTION, 8'h00);
    pb_ext <= 4'h5;
    rd(`OFS_PB_READBACK, 8'h50);
    $display("pad test done");
    // Every source raised, then only the sync source, so shared slots show their owner
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      unit_cmd <= 10'h00F;
      cfg({3'b000, i[2], 2'b00, i[1:0]}, 8'h00, 6'h00, 2'b00);
      chk({2'b00, p2_fn_used}, used_t[i]);
      chk({5'h00, latch_slot_seven, latch_slot_six, latch_slot_fifteen}, slot_t[i]);
      @(posedge clk_sys);
      unit_cmd <= 10'h002;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({5'h00, latch_slot_seven, latch_slot_six, latch_slot_fifteen}, sync_t[i]);
    end
    $display("selection test done");
    @(posedge clk_sys);
    unit_cmd <= 10'h000;
    cfg(8'h00, 8'h00, 6'h0A, 2'b10);
    chk({7'h0, async0_receive}, 8'h01);
    chk({6'h0, two_wire0_data, two_wire0_clock}, 8'h02);
    chk({7'h0, async1_receive}, 8'h01);
    chk({7'h0, timer_a0_capture}, 8'h01);
    chk({7'h0, p2_fn_out[0]}, 8'h00);
    cfg(8'h40, 8'h03, 6'h0A, 2'b10);
    chk({6'h0, async0_receive, async1_receive}, 8'h00);
    chk({7'h0, timer_a0_capture}, 8'h01);
    chk({7'h0, p2_fn_out[1]}, 8'h00);
    cfg(8'h81, 8'h00, 6'h12, 2'b10);
    chk({6'h0, sync0_serial_in, async0_receive}, 8'h03);
    chk({7'h0, timer_a0_capture}, 8'h00);
    chk({2'b00, p2_fn_out}, 8'h16);
    // Routed outputs differ from the latch so the alternate bit is visible
    @(posedge clk_sys);
    unit_cmd <= 10'h280;
    pb_ext <= 4'h2;
    wr(`OFS_PB_LATCH, 8'h00);
    wr(`OFS_PB_ALT_FUNC, 8'h10);
    wr(`OFS_PB_DIRECTION, 8'h10);
    cfg(8'h10, 8'h00, 6'h00, 2'b00);
    chk({6'h0, async0_receive, pb_out[0]}, 8'h03);
    wr(`OFS_PB_ALT_FUNC, 8'h00);
    cfg(8'h12, 8'h00, 6'h00, 2'b00);
    chk({6'h0, sync0_serial_in, pb_out[0]}, 8'h02);
    $display("placement test done");
    final_report();
  end
endmodule  // serial_pin_interrupt_router_test
`default_nettype wire
